// >>> hw/jk_dual_rank.sv
// double-rank j-k storage element, modelled on the system clock
`timescale 1ns/10ps
// Notes on behaviour
// - steer inputs are active at one, and a zero-one-zero pulse on the element clock loads the steered state.
// - the set term is the and of all set-steer inputs and the reset term the and of all reset-steer inputs.
// - the preset term is the and of two preset inputs, the clear term the and of three, each active low.
// - with both steer terms at one the pulse inverts the stored state.
// - with only set at one the element stores one, with only reset at one it stores zero.
// - with both steer terms at zero the stored state is kept.
// - the rising clock freezes the first rank and blocks transfer to the output rank.
// - the falling clock moves the first rank into the output rank unless a steer has triggered, and the first rank follows steers again.
// - a low preset forces one and a low clear forces zero without waiting for a clock.
// - with preset and clear both low, both the true and the complementary outputs are zero.
// - preset and clear override any clocked steering while active.
// - a set and a reset steer joined as a second clock make the element act on the and with the main clock.
// - trailing-edge transfer lets outputs feed steer inputs on the same clock without racing.
// - while the clock is high the first steer to fall triggers, set leaving one and reset leaving zero.
module jk_dual_rank (
  input  wire logic                     clk_sys,  // sampling clock, 40 MHz
  input  wire logic                     rst,      // asynchronous reset, active high
  input  wire logic                     ff_clk,   // element clock, sampled level
  input  wire jk_dual_rank_pkg::steer_s steer,    // set and reset steer inputs
  input  wire jk_dual_rank_pkg::async_s dc_in,    // preset and clear, active low
  output logic                          q,        // true output
  output logic                          q_bar     // complementary output
);
  import jk_dual_rank_pkg::*;

  // ************************************************************
  // input terms
  // ************************************************************
  logic        set_term;
  logic        reset_term;
  logic        preset_act;
  logic        clear_act;
  logic        clk_ff;
  logic        set_ff;
  logic        reset_ff;
  logic        first_ff;
  logic        state_ff;
  logic        nxt_first;
  logic        nxt_state;
  logic        clk_rise;
  logic        clk_fall;
  logic        set_fell;
  logic        reset_fell;
  logic        armed_ff;
  steer_mode_e mode;

  assign set_term   = &steer.set_steer;
  assign reset_term = &steer.reset_steer;
  assign preset_act = ~(&dc_in.preset_n);
  assign clear_act  = ~(&dc_in.clear_n);
  assign mode       = steer_mode_e'({set_term, reset_term});

  // ************************************************************
  // edge and trigger detection
  // ************************************************************
  // a steer fall counts only from the second high sample on
  assign clk_rise   = ff_clk & ~clk_ff;
  assign clk_fall   = ~ff_clk & clk_ff;
  assign set_fell   = ff_clk & clk_ff & set_ff & ~set_term;
  assign reset_fell = ff_clk & clk_ff & reset_ff & ~reset_term;

  // ************************************************************
  // edge history
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_ff   <= 1'h0;
      set_ff   <= 1'h0;
      reset_ff <= 1'h0;
    end else begin
      clk_ff   <= ff_clk;
      set_ff   <= set_term;
      reset_ff <= reset_term;
    end
  end

  // ************************************************************
  // first rank: follows steers while clock low, frozen once high
  // ************************************************************
  always_comb begin
    case (mode)
      MODE_HOLD:   nxt_first = state_ff;
      MODE_RESET:  nxt_first = 1'b0;
      MODE_SET:    nxt_first = 1'b1;
      MODE_TOGGLE: nxt_first = ~state_ff;
      default:     nxt_first = state_ff;
    endcase
  end

  // armed while the clock is high and no steer has triggered yet
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_ff <= 1'h0;
    end else if (clk_rise) begin
      armed_ff <= 1'b1;
    end else if (!ff_clk || set_fell || reset_fell) begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_ff <= RANK_RST;
    end else if (!ff_clk) begin
      first_ff <= nxt_first;
    end else if (clk_rise) begin
      first_ff <= nxt_first;
    end
  end

  // ************************************************************
  // output rank with asynchronous preset and clear
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    if (clk_fall && armed_ff) begin
      nxt_state = first_ff;
    end else if (armed_ff && set_fell && reset_fell) begin
      nxt_state = first_ff;
    end else if (armed_ff && set_fell) begin
      nxt_state = 1'b1;
    end else if (armed_ff && reset_fell) begin
      nxt_state = 1'b0;
    end
    if (clear_act) begin
      nxt_state = 1'b0;
    end else if (preset_act) begin
      nxt_state = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // preset and clear act on the outputs at once, not after a clock
  always_comb begin
    if (preset_act && clear_act) begin
      q     = 1'b0;
      q_bar = 1'b0;
    end else if (clear_act) begin
      q     = 1'b0;
      q_bar = 1'b1;
    end else if (preset_act) begin
      q     = 1'b1;
      q_bar = 1'b0;
    end else begin
      q     = state_ff;
      q_bar = ~state_ff;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_TOGGLE: assert property (
    !ff_clk ##1 (ff_clk && set_term && reset_term && !preset_act && !clear_act)
      ##1 (ff_clk && !preset_act && !clear_act && !set_fell && !reset_fell)
      ##1 (!ff_clk && !preset_act && !clear_act)
    |=> state_ff == !$past(state_ff, 3))
    else $error("toggle did not invert state");
  AST_SET: assert property (
    !ff_clk ##1 (ff_clk && set_term && !reset_term && !preset_act && !clear_act)
      ##1 (ff_clk && !preset_act && !clear_act)
      ##1 (!ff_clk && !preset_act && !clear_act) |=> state_ff)
    else $error("set pulse did not store one");
  AST_RESET: assert property (
    !ff_clk ##1 (ff_clk && !set_term && reset_term && !preset_act && !clear_act)
      ##1 (ff_clk && !preset_act && !clear_act)
      ##1 (!ff_clk && !preset_act && !clear_act) |=> !state_ff)
    else $error("reset pulse did not store zero");
  AST_HOLD_LOW: assert property (
    (!ff_clk && !clk_ff && !preset_act && !clear_act) |=> $stable(state_ff))
    else $error("state moved while clock held low");
  AST_FROZEN: assert property (
    (ff_clk && clk_ff) |=> $stable(first_ff))
    else $error("first rank changed while clock high");
  AST_DC_CLEAR: assert property (
    clear_act && !preset_act |-> !q && q_bar ##1 (!clear_act || !state_ff))
    else $error("clear did not force zero");
  AST_DC_PRESET: assert property (
    preset_act && !clear_act |-> q && !q_bar ##1 (!preset_act || clear_act || state_ff))
    else $error("preset did not force one");
  AST_BOTH_LOW: assert property (
    preset_act && clear_act |-> !q && !q_bar)
    else $error("outputs not both zero");
  AST_COMPL: assert property (
    !(preset_act && clear_act) |-> q_bar == !q)
    else $error("complement output wrong");
  AST_FALL_SET: assert property (
    (armed_ff && set_fell && !reset_fell && !preset_act && !clear_act) |=> state_ff)
    else $error("falling set steer did not leave one");
  AST_FALL_RESET: assert property (
    (armed_ff && reset_fell && !set_fell && !preset_act && !clear_act) |=> !state_ff)
    else $error("falling reset steer did not leave zero");
  AST_JOINED_FALL: assert property (
    (armed_ff && set_fell && reset_fell && !preset_act && !clear_act) |=> state_ff == $past(first_ff))
    else $error("joined second clock did not load the first rank");
  AST_RANK_LOAD: assert property (
    (clk_fall && armed_ff && !preset_act && !clear_act) |=> state_ff == $past(first_ff))
    else $error("trailing edge did not load the first rank");
  AST_TRIG_ONCE: assert property (
    (clk_fall && !armed_ff && !preset_act && !clear_act) |=> $stable(state_ff))
    else $error("trailing edge acted after a steer trigger");
  AST_HIGH_STABLE: assert property (
    (ff_clk && !set_fell && !reset_fell && !preset_act && !clear_act) |=> $stable(state_ff))
    else $error("state moved while clock high without a trigger");
  AST_FIRST_SET: assert property (
    ((!ff_clk || !clk_ff) && set_term && !reset_term) |=> first_ff)
    else $error("first rank did not take the set steer");
  AST_FIRST_RESET: assert property (
    ((!ff_clk || !clk_ff) && !set_term && reset_term) |=> !first_ff)
    else $error("first rank did not take the reset steer");

  // main scenarios reached by the bench
  COV_TOGGLE: cover property (clk_fall && armed_ff && mode == MODE_TOGGLE);
  COV_DC_BOTH: cover property (preset_act && clear_act);
  COV_STEER_TRIG: cover property (armed_ff && (set_fell || reset_fell));
  COV_JOINED_FALL: cover property (armed_ff && set_fell && reset_fell);
  COV_CLEAR_PULSE: cover property (clk_fall && clear_act);

endmodule

// >>> hw/jk_dual_rank_pkg.sv
// shared types and constants for the double-rank j-k storage element
package jk_dual_rank_pkg;

  localparam int unsigned SET_STEER_W   = 2;
  localparam int unsigned RESET_STEER_W = 2;
  localparam int unsigned PRESET_W      = 2;
  localparam int unsigned CLEAR_W       = 3;
  localparam logic        STATE_RST     = 1'h0;
  localparam logic        RANK_RST      = 1'h0;

  typedef struct packed {
    logic [SET_STEER_W-1:0]   set_steer;
    logic [RESET_STEER_W-1:0] reset_steer;
  } steer_s;

  typedef struct packed {
    logic [PRESET_W-1:0] preset_n;
    logic [CLEAR_W-1:0]  clear_n;
  } async_s;

  typedef enum logic [1:0] {
    MODE_HOLD   = 2'h0,
    MODE_RESET  = 2'h1,
    MODE_SET    = 2'h2,
    MODE_TOGGLE = 2'h3
  } steer_mode_e;

endpackage

// >>> verification/jk_pulse_src.sv
// partner model: surrounding logic that pulses the element clock
`timescale 1ns/10ps
module jk_pulse_src (
  input  wire logic       clk_sys, // system clock
  input  wire logic       rst,     // reset, active high
  input  wire logic       go,      // start a pulse
  input  wire logic [2:0] len,     // samples held high
  output logic            ff_clk   // element clock
);
  logic [2:0] cnt_ff;
  // callers hold gating steers steady while the pulse is high, except fall_pulse, which drops them mid-pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ff_clk <= 1'h0;
      cnt_ff <= 3'h0;
    end else if (go && !ff_clk) begin
      ff_clk <= 1'h1;
      cnt_ff <= len;
    end else if (ff_clk) begin
      cnt_ff <= cnt_ff - 3'h1;
      if (cnt_ff == 3'h1) ff_clk <= 1'h0;
    end
  end
endmodule

// >>> verification/jk_dual_rank_bench.sv
// self-checking bench for the double-rank j-k element
`timescale 1ns/10ps
module jk_dual_rank_bench;
  import jk_dual_rank_pkg::*;
  logic       clk_sys = 1'h0;
  logic       rst = 1'h1;
  logic       go = 1'h0;
  logic [2:0] len = 3'h2;
  logic       ff_clk;
  steer_s     steer = '0;
  async_s     dc_in = '1;
  logic       q;
  logic       q_bar;
  int         err_total = 0;
  int         num_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  jk_pulse_src i_jk_pulse_src (.clk_sys(clk_sys), .rst(rst), .go(go), .len(len), .ff_clk(ff_clk));
  jk_dual_rank i_jk_dual_rank (.clk_sys(clk_sys), .rst(rst), .ff_clk(ff_clk), .steer(steer), .dc_in(dc_in),
                               .q(q), .q_bar(q_bar));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_out(input logic eq, input logic eqb);
    chk("q", eq, q);
    chk("q_bar", eqb, q_bar);
  endtask
  // one element clock pulse, output must stand through the high phase
  task automatic pulse(input logic eq);
    logic old;
    old = q;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    while (ff_clk === 1'h1) begin
      chk("q while high", old, q);
      tick(1);
    end
    tick(2);
    chk_out(eq, ~eq);
  endtask
  task automatic test_modes();
    steer_mode_e m [6] = '{MODE_SET, MODE_HOLD, MODE_RESET, MODE_TOGGLE, MODE_TOGGLE, MODE_SET};
    logic        e [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
    for (int i = 0; i < 6; i++) begin
      steer = '{set_steer: (i == 5) ? 2'h1 : (m[i][1] ? 2'h3 : 2'h0), reset_steer: m[i][0] ? 2'h3 : 2'h0};
      pulse(e[i]);
    end
  endtask
  // toggle steers, then fall_to lands while the clock is high; the trailing edge must not act again
  task automatic fall_pulse(input steer_s fall_to, input logic eq);
    steer = '{set_steer: 2'h3, reset_steer: 2'h3};
    len = 3'h5;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(2);
    steer = fall_to;
    tick(2);
    chk("q steer fall", eq, q);
    while (ff_clk === 1'h1) tick(1);
    tick(2);
    chk("q after trailing edge", eq, q);
  endtask
  task automatic test_direct();
    steer = '{set_steer: 2'h3, reset_steer: 2'h0};
    pulse(1'h1);
    fall_pulse('{set_steer: 2'h2, reset_steer: 2'h3}, 1'h1);
    fall_pulse('{set_steer: 2'h1, reset_steer: 2'h1}, 1'h0);
    fall_pulse('{set_steer: 2'h3, reset_steer: 2'h1}, 1'h0);
    len = 3'h2;
  endtask
  task automatic test_async();
    steer = '{set_steer: 2'h3, reset_steer: 2'h0};
    dc_in.clear_n = 3'h6;
    #1;
    chk_out(1'h0, 1'h1);
    pulse(1'h0);
    dc_in.preset_n = 2'h1;
    #1;
    chk_out(1'h0, 1'h0);
    dc_in = '1;
    tick(2);
    chk_out(1'h0, 1'h1);
    dc_in.preset_n = 2'h2;
    steer = '{set_steer: 2'h3, reset_steer: {1'h1, &dc_in.preset_n}};
    #1;
    chk_out(1'h1, 1'h0);
    pulse(1'h1);
    dc_in = '1;
    tick(2);
    chk_out(1'h1, 1'h0);
  endtask
  task automatic test_reset();
    rst = 1'h1;
    #1;
    chk_out(1'h0, 1'h1);
    tick(2);
    rst = 1'h0;
    tick(2);
    chk_out(1'h0, 1'h1);
    pulse(1'h1);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #20us;
    err_total++;
    close_out();
  end
  initial begin
    tick(3);
    rst = 1'h0;
    tick(2);
    chk_out(1'h0, 1'h1);
    test_modes();
    test_direct();
    test_async();
    test_reset();
    close_out();
  end
endmodule
